/* File: logic/lut_defs.svh */
// Constants shared by the lookup table design.
`ifndef LUT_DEFS_SVH
`define LUT_DEFS_SVH
`define LUT_POINTS 11
`define LUT_LAST_POINT 10
`define LUT_DATA_W 32
`define LUT_INDEX_W 4
`define LUT_SEL_W 8
`define LUT_ZERO 32'sh00000000
`define LUT_PCT_FLOOR 32'sh00000000
`define LUT_PCT_CEIL 32'sh00000064
`define LUT_X_SPAN_STEPS 9
`define LUT_Y_SPAN_STEPS 10
`define LUT_DRIVE_TABLES 4
`define LUT_RST_SOURCE_NONE 8'h00
`define LUT_RST_AXIS 1'b0
`endif

/* File: logic/lut_pkg.sv */
// Types shared by the lookup table design.
`include "lut_defs.svh"
package lut_pkg;
	typedef logic signed [`LUT_DATA_W-1:0] data_t;
	typedef enum logic [1:0] {
		END_OF_TABLE = 2'h0,
		INTERPOLATE_SEGMENT = 2'h1,
		STEP_SEGMENT = 2'h2
	} response_t;
	typedef enum logic [2:0] {
		FIELD_RESPONSE = 3'h0,
		FIELD_X = 3'h1,
		FIELD_Y = 3'h2,
		FIELD_SOURCE = 3'h3,
		FIELD_AXIS_TYPE = 3'h4
	} cfg_field_t;
	typedef enum logic {
		AXIS_DATA = 1'b0,
		AXIS_TIME = 1'b1
	} axis_type_t;
	typedef struct packed {
		logic we;
		cfg_field_t field;
		logic [`LUT_INDEX_W-1:0] index;
		data_t data;
	} cfg_write_t;
	typedef struct packed {
		data_t value;
		data_t lower;
		data_t upper;
	} source_t;
	typedef struct packed {
		data_t floor;
		data_t ceiling;
	} range_t;
endpackage

/* File: logic/lut_interp.sv */
// Linear interpolation between two breakpoints.
`timescale 1ns/100ps
`default_nettype none
`include "lut_defs.svh"
module lut_interp (
	// Segment end points.
	input wire lut_pkg::data_t xLo,
	input wire lut_pkg::data_t xHi,
	input wire lut_pkg::data_t yLo,
	input wire lut_pkg::data_t yHi,
	// Input value, already inside the segment.
	input wire lut_pkg::data_t value,
	// Interpolated result.
	output lut_pkg::data_t result
);
	logic signed [67:0] dx;
	logic signed [67:0] dy;
	logic signed [67:0] dv;
	logic signed [67:0] scaled;

	assign dx = 68'(xHi) - 68'(xLo);
	assign dy = 68'(yHi) - 68'(yLo);
	assign dv = 68'(value) - 68'(xLo);
	// A zero-width segment has no slope, so it jumps straight to its end value.
	assign scaled = (dx > 68'sh0) ? (dy * dv) / dx : dy;
	assign result = 32'(68'(yLo) + scaled);
endmodule
`default_nettype wire

/* File: logic/piecewise_lookup_table.sv */
// Piecewise lookup table with eleven breakpoints and default reload.
//
// Contract
// (R1) Eleven response, X and Y entries per table.
// (R2) Source or limit change reloads all defaults.
// (R3) Axis type change reloads; data response default.
// (R4) Point 1 source minimum, point 10 maximum.
// (R5) Point 0 X is zero, or negative minimum.
// (R6) X breakpoints ordered, inside the source range; code clamps written X into the range but does not enforce order.
// (R7) All Y within 0..100 reports 0 and 100.
// (R8) Otherwise report lowest and highest Y values.
// (R9) Ended points still count toward output limits.
// (R10) Tables 1..4 use inputs 1..4, drive range.
// (R11) Tables 5..16 unselected; Y defaults 0..100.
// (R12) Defaults spaced equally from minimum to maximum.
// (R13) Points 1..10 default to linear interpolation.
// (R14) Step point N outputs Y of N.
// (R15) End point N: above X(N-1) gives Y(N-1).
// (R16) Configure source before writing breakpoint values.
// (R17) Below point 0 gives Y0; above last gives last.
// (R18) Output and limits recomputed on every change.
`timescale 1ns/100ps
`default_nettype none
`include "lut_defs.svh"
module piecewise_lookup_table #(
	parameter int TABLE_NUM = 1
) (
	// Clock, reset and enable.
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clkEn,
	// Configuration writes.
	input wire lut_pkg::cfg_write_t cfgWrite,
	// Selected source value with its limits, and the drive range.
	input wire lut_pkg::source_t sourceIn,
	input wire lut_pkg::range_t driveRange,
	// Settings toward the source selector.
	output var logic [`LUT_SEL_W-1:0] sourceSelect,
	output var lut_pkg::axis_type_t axisType,
	// Result toward downstream consumers.
	output var lut_pkg::data_t tableOutput,
	output var lut_pkg::range_t outputRange,
	output var logic reloadBusy
);
	localparam int NPT = `LUT_POINTS;
	localparam int LAST = `LUT_LAST_POINT;
	localparam bit DRIVE_TABLE = (TABLE_NUM <= `LUT_DRIVE_TABLES);
	localparam logic [`LUT_SEL_W-1:0] RST_SEL =
		DRIVE_TABLE ? `LUT_SEL_W'(TABLE_NUM) : `LUT_RST_SOURCE_NONE;

	lut_pkg::response_t resp_r [NPT];
	lut_pkg::data_t xPt_r [NPT];
	lut_pkg::data_t yPt_r [NPT];
	lut_pkg::data_t defX [NPT];
	lut_pkg::data_t defY [NPT];
	logic [NPT-1:0] xHit;
	logic [NPT-1:0] yHit;
	logic [NPT-1:0] respHit;
	logic [NPT-1:0] abovePt;
	logic [NPT-1:0] endPt;
	logic [`LUT_SEL_W-1:0] srcSel_r;
	lut_pkg::axis_type_t axis_r;
	logic reloadPend_r;
	lut_pkg::data_t prevLower_r;
	lut_pkg::data_t prevUpper_r;
	logic selWrite;
	logic axisWrite;
	logic limitChange;
	logic doReload;
	logic reloadPend_nxt;
	lut_pkg::data_t clampX;
	lut_pkg::data_t yLoDef;
	lut_pkg::data_t yHiDef;
	logic signed [65:0] spanX;
	logic signed [65:0] spanY;
	logic [`LUT_INDEX_W-1:0] lastIdx;
	logic [`LUT_INDEX_W-1:0] segIdx;
	logic [`LUT_INDEX_W-1:0] segPrev;
	logic segFound;
	logic belowX0;
	logic stepSel;
	logic interpSel;
	lut_pkg::data_t flatVal;
	lut_pkg::data_t yMin;
	lut_pkg::data_t yMax;
	logic allPct;
	logic s1Interp_r;
	lut_pkg::data_t s1Flat_r;
	lut_pkg::data_t s1XLo_r;
	lut_pkg::data_t s1XHi_r;
	lut_pkg::data_t s1YLo_r;
	lut_pkg::data_t s1YHi_r;
	lut_pkg::data_t s1Val_r;
	lut_pkg::data_t interpRes;
	lut_pkg::data_t tableOut_r;
	lut_pkg::range_t range_r;

	assign selWrite = cfgWrite.we && (cfgWrite.field == lut_pkg::FIELD_SOURCE);
	assign axisWrite = cfgWrite.we && (cfgWrite.field == lut_pkg::FIELD_AXIS_TYPE);
	assign limitChange = (sourceIn.lower != prevLower_r) || (sourceIn.upper != prevUpper_r);
	assign doReload = reloadPend_r || limitChange; // [R2]
	assign reloadPend_nxt = selWrite || axisWrite; // [R2] [R3]
	// Written X values are held inside the source range; ordering is left to the writer.
	assign clampX = (cfgWrite.data < sourceIn.lower) ? sourceIn.lower :
		(cfgWrite.data > sourceIn.upper) ? sourceIn.upper : cfgWrite.data; // [R6]
	assign yLoDef = DRIVE_TABLE ? driveRange.floor : `LUT_PCT_FLOOR; // [R10] [R11]
	assign yHiDef = DRIVE_TABLE ? driveRange.ceiling : `LUT_PCT_CEIL; // [R10] [R11]
	assign spanX = 66'(sourceIn.upper) - 66'(sourceIn.lower);
	assign spanY = 66'(yHiDef) - 66'(yLoDef);

	// Settings, reload request and limit history.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			srcSel_r <= RST_SEL; // [R10] [R11]
			axis_r <= lut_pkg::AXIS_DATA; // [R3]
			reloadPend_r <= 1'b1;
			prevLower_r <= `LUT_ZERO;
			prevUpper_r <= `LUT_ZERO;
		end else if (clkEn) begin
			if (selWrite) begin
				srcSel_r <= cfgWrite.data[`LUT_SEL_W-1:0];
			end
			if (axisWrite) begin
				axis_r <= lut_pkg::axis_type_t'(cfgWrite.data[0]);
			end
			reloadPend_r <= reloadPend_nxt;
			prevLower_r <= sourceIn.lower;
			prevUpper_r <= sourceIn.upper;
		end
	end

	// One storage slot per breakpoint, with its default value.
	for (genvar i = 0; i < NPT; i++) begin : gPoint // [R1]
		if (i == 0) begin : gZero
			assign defX[i] = (sourceIn.lower < `LUT_ZERO) ? sourceIn.lower : `LUT_ZERO; // [R5]
			assign endPt[i] = 1'b0;
		end else begin : gRest
			assign defX[i] = 32'(66'(sourceIn.lower) +
				(spanX * (i - 1)) / `LUT_X_SPAN_STEPS); // [R4] [R12]
			assign endPt[i] = (resp_r[i] == lut_pkg::END_OF_TABLE);
		end
		assign defY[i] = 32'(66'(yLoDef) + (spanY * i) / `LUT_Y_SPAN_STEPS); // [R12]
		assign xHit[i] = cfgWrite.we && (cfgWrite.field == lut_pkg::FIELD_X) &&
			(cfgWrite.index == `LUT_INDEX_W'(i));
		assign yHit[i] = cfgWrite.we && (cfgWrite.field == lut_pkg::FIELD_Y) &&
			(cfgWrite.index == `LUT_INDEX_W'(i));
		// Point 0 can never end the table, and code 3 is not a response.
		assign respHit[i] = cfgWrite.we && (cfgWrite.field == lut_pkg::FIELD_RESPONSE) &&
			(cfgWrite.index == `LUT_INDEX_W'(i)) && (i != 0) && (cfgWrite.data[1:0] != 2'h3);
		assign abovePt[i] = (sourceIn.value > xPt_r[i]);
		// A reload overrides a point write in the same cycle, which is why the source comes first.
		always_ff @(posedge core_clk or negedge rstn) begin
			if (!rstn) begin
				resp_r[i] <= lut_pkg::INTERPOLATE_SEGMENT;
				xPt_r[i] <= `LUT_ZERO;
				yPt_r[i] <= `LUT_ZERO;
			end else if (clkEn && doReload) begin
				resp_r[i] <= lut_pkg::INTERPOLATE_SEGMENT; // [R13] [R16]
				xPt_r[i] <= defX[i]; // [R2]
				yPt_r[i] <= defY[i];
			end else if (clkEn) begin
				if (respHit[i]) begin
					resp_r[i] <= lut_pkg::response_t'(cfgWrite.data[1:0]);
				end
				if (xHit[i]) begin
					xPt_r[i] <= clampX;
				end
				if (yHit[i]) begin
					yPt_r[i] <= cfgWrite.data; // [R8]
				end
			end
		end
	end

	// Last active point and the segment that holds the input.
	always_comb begin
		lastIdx = `LUT_INDEX_W'(LAST);
		for (int k = LAST; k >= 1; k--) begin
			if (endPt[k]) begin
				lastIdx = `LUT_INDEX_W'(k - 1); // [R15]
			end
		end
		segIdx = lastIdx; // [R17]
		segFound = 1'b0;
		for (int k = 1; k <= LAST; k++) begin
			if (!segFound && (`LUT_INDEX_W'(k) <= lastIdx) && !abovePt[k]) begin
				segIdx = `LUT_INDEX_W'(k);
				segFound = 1'b1;
			end
		end
	end

	assign belowX0 = !abovePt[0];
	assign stepSel = !belowX0 && segFound && (resp_r[segIdx] == lut_pkg::STEP_SEGMENT);
	assign interpSel = !belowX0 && segFound && !stepSel; // [R13]
	assign segPrev = segFound ? segIdx - `LUT_INDEX_W'(1) : segIdx;
	assign flatVal = belowX0 ? yPt_r[0] : yPt_r[segIdx]; // [R14] [R17]

	// Output limits look at every Y, including points past an end of table.
	always_comb begin
		yMin = yPt_r[0];
		yMax = yPt_r[0];
		for (int k = 1; k < NPT; k++) begin
			if (yPt_r[k] < yMin) begin
				yMin = yPt_r[k]; // [R9]
			end
			if (yPt_r[k] > yMax) begin
				yMax = yPt_r[k]; // [R9]
			end
		end
	end

	assign allPct = (yMin >= `LUT_PCT_FLOOR) && (yMax <= `LUT_PCT_CEIL);

	lut_interp uInterp (
		.xLo(s1XLo_r),
		.xHi(s1XHi_r),
		.yLo(s1YLo_r),
		.yHi(s1YHi_r),
		.value(s1Val_r),
		.result(interpRes)
	);

	// Two stages split the search from the divide; the cost is two cycles of latency.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s1Interp_r <= 1'b0;
			s1Flat_r <= `LUT_ZERO;
			s1XLo_r <= `LUT_ZERO;
			s1XHi_r <= `LUT_ZERO;
			s1YLo_r <= `LUT_ZERO;
			s1YHi_r <= `LUT_ZERO;
			s1Val_r <= `LUT_ZERO;
			tableOut_r <= `LUT_ZERO;
			range_r <= '0;
		end else if (clkEn) begin
			s1Interp_r <= interpSel; // [R18]
			s1Flat_r <= flatVal;
			s1XLo_r <= xPt_r[segPrev];
			s1XHi_r <= xPt_r[segIdx];
			s1YLo_r <= yPt_r[segPrev];
			s1YHi_r <= yPt_r[segIdx];
			s1Val_r <= sourceIn.value;
			tableOut_r <= s1Interp_r ? interpRes : s1Flat_r; // [R18]
			range_r.floor <= allPct ? `LUT_PCT_FLOOR : yMin; // [R7] [R8]
			range_r.ceiling <= allPct ? `LUT_PCT_CEIL : yMax; // [R7] [R8]
		end
	end

	assign sourceSelect = srcSel_r;
	assign axisType = axis_r;
	assign tableOutput = tableOut_r;
	assign outputRange = range_r;
	assign reloadBusy = reloadPend_r;

	// The sampled reset term stops an attempt on the releasing edge, where flops still reset.
	reload_upper_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R2]
		rstn && clkEn && limitChange |=> xPt_r[LAST] == $past(sourceIn.upper))
		else $error("Point 10 X did not take the new source maximum.");

	point_one_min_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R4]
		rstn && clkEn && doReload |=> xPt_r[1] == $past(sourceIn.lower) &&
			yPt_r[LAST] == $past(yHiDef))
		else $error("Reload did not place point 1 X or point 10 Y.");

	point_zero_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R5]
		rstn && clkEn && doReload |=> xPt_r[0] == (($past(sourceIn.lower) < `LUT_ZERO) ?
			$past(sourceIn.lower) : `LUT_ZERO))
		else $error("Point 0 X default is wrong.");

	axis_reload_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R3]
		clkEn && axisWrite ##1 clkEn |=> resp_r[1] == lut_pkg::INTERPOLATE_SEGMENT &&
			yPt_r[0] == $past(defY[0]) && xPt_r[0] == $past(defX[0]))
		else $error("Axis type change did not reload the table.");

	range_pct_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R7]
		rstn && clkEn && allPct |=> outputRange.floor == `LUT_PCT_FLOOR &&
			outputRange.ceiling == `LUT_PCT_CEIL)
		else $error("Percent limits not reported.");

	range_span_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R8]
		clkEn && !allPct |=> outputRange.floor == $past(yMin) && outputRange.ceiling == $past(yMax))
		else $error("Output limits do not match the Y extremes.");

	write_clamp_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R6]
		clkEn && !doReload && xHit[LAST] |=> xPt_r[LAST] >= $past(sourceIn.lower) &&
			xPt_r[LAST] <= $past(sourceIn.upper))
		else $error("Written X left the source range.");

	step_out_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R14]
		clkEn && stepSel ##1 clkEn |=> tableOutput == $past(yPt_r[segIdx], 2))
		else $error("Step segment did not output its end value.");

	below_zero_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R17]
		clkEn && belowX0 ##1 clkEn |=> tableOutput == $past(yPt_r[0], 2))
		else $error("Input below point 0 did not give Y0.");

	past_end_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R15]
		clkEn && !belowX0 && !segFound ##1 clkEn |=> tableOutput == $past(yPt_r[lastIdx], 2))
		else $error("Input past the last point did not hold its Y.");

	enable_freeze_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R18]
		rstn && !clkEn |=> $stable(tableOutput) && $stable(outputRange) &&
			$stable(reloadBusy))
		else $error("Outputs moved while the clock enable was low.");
endmodule
`default_nettype wire

/* File: sim/source_model.sv */
// Behavioural model of the source selector and drive range feeding the table.
`timescale 1ns/100ps
`default_nettype none
module source_model (
	// Clock.
	input wire logic core_clk,
	// Source value and limits, and drive range.
	output var lut_pkg::source_t sourceIn,
	output var lut_pkg::range_t driveRange
);
	initial begin
		sourceIn = '0;
		driveRange = '0;
	end
	// Limits only move together with the value, as a real source mux would present them.
	task automatic set_src(input lut_pkg::data_t v, input lut_pkg::data_t lo, input lut_pkg::data_t hi);
		@(posedge core_clk);
		sourceIn <= '{value: v, lower: lo, upper: hi};
	endtask
	task automatic set_drive(input lut_pkg::data_t f, input lut_pkg::data_t c);
		@(posedge core_clk);
		driveRange <= '{floor: f, ceiling: c};
	endtask
endmodule
`default_nettype wire

/* File: sim/piecewise_lookup_table_bench.sv */
// Self-checking bench for the piecewise lookup table.
`timescale 1ns/100ps
`default_nettype none
module piecewise_lookup_table_bench;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic clkEn = 1'b1;
	lut_pkg::cfg_write_t cfgWrite = '0;
	lut_pkg::source_t sourceIn;
	lut_pkg::range_t driveRange;
	logic [7:0] sourceSelect;
	logic [7:0] sel5;
	lut_pkg::axis_type_t axisType;
	lut_pkg::data_t tableOutput;
	lut_pkg::range_t outputRange;
	lut_pkg::range_t range5;
	logic reloadBusy;
	lut_pkg::data_t curLo;
	lut_pkg::data_t curHi;
	int error_cnt = 0;
	int checks = 0;
	lut_pkg::data_t vIn[6] = '{-32'sh32, -32'sh28, -32'sh27, -32'sh1E, 32'sh32, 32'sh3C};
	lut_pkg::data_t vExp[6] = '{32'sh0, 32'sh0, 32'sh6E, 32'shC8, 32'sh3E8, 32'sh3E8};
	always #2.5 core_clk = ~core_clk;
	source_model sm (.core_clk(core_clk), .sourceIn(sourceIn), .driveRange(driveRange));
	piecewise_lookup_table #(.TABLE_NUM(1)) dut (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
		.cfgWrite(cfgWrite), .sourceIn(sourceIn), .driveRange(driveRange),
		.sourceSelect(sourceSelect), .axisType(axisType), .tableOutput(tableOutput),
		.outputRange(outputRange), .reloadBusy(reloadBusy));
	// A general-purpose table shares the stimulus; only its reset-time behaviour is judged.
	piecewise_lookup_table #(.TABLE_NUM(5)) dut5 (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
		.cfgWrite(cfgWrite), .sourceIn(sourceIn), .driveRange(driveRange),
		.sourceSelect(sel5), .axisType(), .tableOutput(), .outputRange(range5), .reloadBusy());
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check(input lut_pkg::data_t got, input lut_pkg::data_t exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 20; i++) begin
			if (reloadBusy === 1'b0) begin
				return;
			end
			@(posedge core_clk);
		end
		error_cnt++;
		$display("BAD t=%0t got=%h exp=%h", $time, reloadBusy, 1'b0);
		tally_and_finish();
	endtask
	task automatic wr(input lut_pkg::cfg_field_t f, input logic [3:0] idx, input lut_pkg::data_t d);
		@(posedge core_clk);
		cfgWrite <= '{we: 1'b1, field: f, index: idx, data: d};
		@(posedge core_clk);
		cfgWrite.we <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		wait_idle();
	endtask
	task automatic look(input lut_pkg::data_t v, input lut_pkg::data_t exp);
		sm.set_src(v, curLo, curHi);
		repeat (3) @(posedge core_clk);
		#1;
		check(tableOutput, exp);
	endtask
	task automatic limits(input lut_pkg::data_t lo, input lut_pkg::data_t hi);
		curLo = lo;
		curHi = hi;
		sm.set_src(32'sh0, lo, hi);
		repeat (4) @(posedge core_clk);
		#1;
		wait_idle();
	endtask
	initial begin
		curLo = -32'sh28;
		curHi = 32'sh32;
		sm.set_drive(32'sh0, 32'sh3E8);
		sm.set_src(32'sh0, curLo, curHi);
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		check(32'(sourceSelect), 32'sh1);
		check(32'(axisType), 32'sh0);
		repeat (2) @(posedge core_clk);
		#1;
		wait_idle();
		check(32'(sel5), 32'sh0);
		check(range5.ceiling, 32'sh64);
		check(outputRange.ceiling, 32'sh3E8);
		for (int i = 0; i < 6; i++) begin
			look(vIn[i], vExp[i]);
		end
		$display("test defaults done");
		wr(lut_pkg::FIELD_RESPONSE, 4'h2, 32'sh2);
		look(-32'sh23, 32'shC8);
		wr(lut_pkg::FIELD_RESPONSE, 4'h5, 32'sh0);
		look(32'sh0, 32'sh190);
		wr(lut_pkg::FIELD_Y, 4'hA, 32'sh7D0);
		check(outputRange.ceiling, 32'sh7D0);
		$display("test responses done");
		// The source limits are set before this section's point writes, so only the earlier response and Y writes are lost to the reload.
		sm.set_drive(32'sh0, 32'sh64);
		limits(32'sh0, 32'sh5A);
		look(32'sh5, 32'shF);
		check(outputRange.floor, 32'sh0);
		wr(lut_pkg::FIELD_Y, 4'hA, 32'sh32);
		check(outputRange.ceiling, 32'sh64);
		wr(lut_pkg::FIELD_Y, 4'h0, -32'sh5);
		check(outputRange.floor, -32'sh5);
		check(outputRange.ceiling, 32'sh5A);
		wr(lut_pkg::FIELD_X, 4'hA, 32'sh3E8);
		look(32'sh5A, 32'sh32);
		$display("test limits done");
		wr(lut_pkg::FIELD_SOURCE, 4'h0, 32'sh3);
		check(32'(sourceSelect), 32'sh3);
		look(32'sh5A, 32'sh64);
		wr(lut_pkg::FIELD_Y, 4'h0, -32'sh5);
		wr(lut_pkg::FIELD_AXIS_TYPE, 4'h0, 32'sh1);
		check(32'(axisType), 32'sh1);
		check(outputRange.floor, 32'sh0);
		$display("test reloads done");
		// A low enable must freeze the pipeline even though the source value moves.
		@(posedge core_clk);
		clkEn <= 1'b0;
		sm.set_src(32'sh5, curLo, curHi);
		repeat (3) @(posedge core_clk);
		#1;
		check(tableOutput, 32'sh64);
		check(32'(sourceSelect), 32'sh3);
		@(posedge core_clk);
		clkEn <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		check(tableOutput, 32'shF);
		$display("test enable done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
